/* File: logic/ucas_card.sv */
// Card end: activation, reset answer, suspend and remote wakeup
`timescale 1ns/1ns
`include "ucas_defs.svh"
module ucas_card #(
    parameter int IDLE_CYC = `UCAS_IDLE_CYC,
    parameter int WAKE_CYC = `UCAS_WAKE_CYC,
    // Arbitrary default answer
    parameter logic [`UCAS_ANSWER_LEN*8-1:0] RESET_ANSWER = 64'h0123_4567_89AB_CDEF
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    ucas_link_if.card         link,
    input  wire logic         wakeRequest,
    input  wire logic         extWake,
    output logic              suspended,
    output logic              configured,
    output logic              pullEnable,
    output logic              dataPlusContact,
    output logic              dataMinusContact
);
    ucas_pkg::ucas_stage_t stage_q;
    logic [31:0] idleCnt_q;
    logic [31:0] wakeCnt_q;
    logic [3:0]  ansIdx_q;
    logic        ansBusy_q;
    logic        resume_q;
    logic [1:0]  wakeSync_q;

    // Card-side request pin from outside the clock domain
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wakeSync_q <= 2'h0;
        end else begin
            wakeSync_q <= {wakeSync_q[0], wakeRequest};
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage_q <= ucas_pkg::ST_DETACHED;
        end else if (!link.cardPower) begin
            // Legacy interface kept across the fallback power cycle
            stage_q <= (stage_q == ucas_pkg::ST_FALLBACK) ? ucas_pkg::ST_FALLBACK
                                                          : ucas_pkg::ST_DETACHED;
        end else if (link.busReset) begin
            stage_q <= ucas_pkg::ST_RESET;
        end else begin
            case (stage_q)
                ucas_pkg::ST_DETACHED: stage_q <= ucas_pkg::ST_DETACHED;
                ucas_pkg::ST_RESET: begin
                    if (link.addrAssign) begin
                        stage_q <= ucas_pkg::ST_ADDRESS;
                    end
                end
                ucas_pkg::ST_ADDRESS: begin
                    if (link.powerNeg) begin
                        stage_q <= ucas_pkg::ST_POWER;
                    end
                end
                ucas_pkg::ST_POWER: begin
                    if (link.configOk) begin
                        stage_q <= ucas_pkg::ST_ACTIVE;
                    end else if (link.configFail) begin
                        stage_q <= ucas_pkg::ST_FALLBACK;
                    end
                end
                ucas_pkg::ST_ACTIVE: begin
                    if (idleCnt_q == 32'(IDLE_CYC - 1)) begin
                        stage_q <= ucas_pkg::ST_SUSPEND;
                    end
                end
                ucas_pkg::ST_SUSPEND: begin
                    if (link.busActivity || link.hostResume) begin
                        stage_q <= ucas_pkg::ST_ACTIVE;
                    end else if (resume_q && wakeCnt_q == 32'(WAKE_CYC - 1)) begin
                        stage_q <= ucas_pkg::ST_ACTIVE;
                    end
                end
                default: stage_q <= stage_q;
            endcase
        end
    end

    // Idle timer; any activity restarts it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            idleCnt_q <= 32'h0000_0000;
        end else if (stage_q != ucas_pkg::ST_ACTIVE || link.busActivity || link.hostResume) begin
            idleCnt_q <= 32'h0000_0000;
        end else begin
            idleCnt_q <= idleCnt_q + 32'h0000_0001;
        end
    end

    // Remote wakeup, only when enabled and suspended
    // Once begun it runs full length, even if the host answers early
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            resume_q  <= 1'b0;
            wakeCnt_q <= 32'h0000_0000;
        end else if (resume_q) begin
            resume_q  <= wakeCnt_q != 32'(WAKE_CYC - 1);
            wakeCnt_q <= wakeCnt_q + 32'h0000_0001;
        end else begin
            resume_q  <= stage_q == ucas_pkg::ST_SUSPEND && !link.busActivity
                         && !link.hostResume && link.wakeEnable && wakeSync_q[1];
            wakeCnt_q <= 32'h0000_0000;
        end
    end

    // Same reset answer as the contact interface
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ansBusy_q <= 1'b0;
            ansIdx_q  <= 4'h0;
        end else if (!ansBusy_q) begin
            ansBusy_q <= link.powerOnReq && stage_q == ucas_pkg::ST_ACTIVE;
            ansIdx_q  <= 4'h0;
        end else if (ansIdx_q == 4'(`UCAS_ANSWER_LEN - 1)) begin
            ansBusy_q <= 1'b0;
        end else begin
            ansIdx_q <= ansIdx_q + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            link.answerValid <= 1'b0;
            link.answerByte  <= 8'h00;
            link.answerLast  <= 1'b0;
            link.attach      <= 1'b0;
            link.cardResume  <= 1'b0;
            link.fullSpeed   <= 1'b0;
            suspended        <= 1'b0;
            configured       <= 1'b0;
            pullEnable       <= 1'b0;
            dataPlusContact  <= 1'b0;
            dataMinusContact <= 1'b0;
        end else begin
            link.answerValid <= ansBusy_q;
            link.answerByte  <= ansBusy_q ? RESET_ANSWER[(`UCAS_ANSWER_LEN - 1 - ansIdx_q) * 8 +: 8]
                                          : 8'h00;
            link.answerLast  <= ansBusy_q && ansIdx_q == 4'(`UCAS_ANSWER_LEN - 1);
            link.attach      <= link.cardPower && stage_q != ucas_pkg::ST_FALLBACK;
            // Length sits inside the extended window, so the strap needs no effect
            link.cardResume  <= resume_q;
            link.fullSpeed   <= link.cardPower;
            suspended        <= stage_q == ucas_pkg::ST_SUSPEND;
            configured       <= stage_q == ucas_pkg::ST_ACTIVE;
            // Pull resistor only while traffic is signalled, saving power
            pullEnable       <= link.cardPower && (link.busActivity || resume_q);
            // Idle level while attached, inverted levels while resuming
            dataPlusContact  <= link.cardPower && stage_q != ucas_pkg::ST_FALLBACK
                                && !resume_q;
            dataMinusContact <= resume_q;
        end
    end
endmodule

/* File: logic/ucas_defs.svh */
// Constants and summary of operation for the card link sequencing block
// Summary of operation
// - Reset, then address, power, configure in order
// - Host falls back to contact interface
// - Card returns same reset answer on power-on
// - Host ignores link-irrelevant reset answer fields
// - Card switches line resistors during traffic
// - Card suspends after 3 ms bus idle
// - Host suspends only when interfaces allow
// - Card wakes host by resume signalling
// - Extended wakeup resume lasts 10 to 15 ms
// - Host performs interface wakeup actions
// - Host honours card-reported resume minimums; the host uses a fixed RESUME_CYC, the card reports none
// - Host resume outlasts card wakeup signalling
// - Host may cut power while suspended
// - Both ends run full speed
// - Host drives bus reset after attach
`ifndef UCAS_DEFS_SVH
`define UCAS_DEFS_SVH
`define UCAS_CLK_NS          10
`define UCAS_IDLE_US         3000
`define UCAS_WAKE_MIN_US     10000
`define UCAS_WAKE_MAX_US     15000
`define UCAS_IDLE_CYC        ((`UCAS_IDLE_US * 1000) / `UCAS_CLK_NS)
`define UCAS_WAKE_CYC        (((`UCAS_WAKE_MIN_US + `UCAS_WAKE_MAX_US) / 2 * 1000) / `UCAS_CLK_NS)
`define UCAS_HOST_RES_CYC    (((`UCAS_WAKE_MAX_US + 5000) * 1000) / `UCAS_CLK_NS)
`define UCAS_RESET_CYC       1000
`define UCAS_ANSWER_LEN      8
`endif

/* File: logic/ucas_host.sv */
// Terminal end: bus reset, activation order, fallback and resume
`timescale 1ns/1ns
`include "ucas_defs.svh"
module ucas_host #(
    parameter int RESET_CYC  = `UCAS_RESET_CYC,
    parameter int RESUME_CYC = `UCAS_HOST_RES_CYC
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    ucas_link_if.host         link,
    input  wire logic         powerReq,
    input  wire logic         cfgResult,
    input  wire logic         cfgDone,
    input  wire logic         suspendReq,
    input  wire logic         resumeReq,
    input  wire logic         trafficReq,
    output logic              contactSelect,
    output logic              wakeActions,
    output logic              active
);
    ucas_pkg::ucas_stage_t stage_q;
    logic [31:0] cnt_q;
    logic [1:0]  attSync_q;
    logic [1:0]  resSync_q;
    logic        powerCycle_q;
    logic        remoteWake_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            attSync_q <= 2'h0;
            resSync_q <= 2'h0;
        end else begin
            attSync_q <= {attSync_q[0], link.attach};
            resSync_q <= {resSync_q[0], link.cardResume};
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage_q <= ucas_pkg::ST_DETACHED;
            cnt_q   <= 32'h0000_0000;
        end else if (!powerReq) begin
            stage_q <= ucas_pkg::ST_DETACHED;
            cnt_q   <= 32'h0000_0000;
        end else begin
            case (stage_q)
                ucas_pkg::ST_DETACHED: begin
                    cnt_q <= 32'h0000_0000;
                    if (attSync_q[1]) begin
                        stage_q <= ucas_pkg::ST_RESET;
                    end
                end
                ucas_pkg::ST_RESET: begin
                    cnt_q <= cnt_q + 32'h0000_0001;
                    if (cnt_q == 32'(RESET_CYC - 1)) begin
                        stage_q <= ucas_pkg::ST_ADDRESS;
                    end
                end
                ucas_pkg::ST_ADDRESS: stage_q <= ucas_pkg::ST_POWER;
                ucas_pkg::ST_POWER:   stage_q <= ucas_pkg::ST_CONFIG;
                ucas_pkg::ST_CONFIG: begin
                    if (cfgDone) begin
                        stage_q <= cfgResult ? ucas_pkg::ST_ACTIVE
                                             : ucas_pkg::ST_FALLBACK;
                    end
                end
                ucas_pkg::ST_ACTIVE: begin
                    cnt_q <= 32'h0000_0000;
                    if (suspendReq) begin
                        stage_q <= ucas_pkg::ST_SUSPEND;
                    end
                end
                ucas_pkg::ST_SUSPEND: begin
                    if (cnt_q != 32'h0000_0000) begin
                        cnt_q <= cnt_q + 32'h0000_0001;
                        if (cnt_q == 32'(RESUME_CYC - 1)) begin
                            stage_q <= ucas_pkg::ST_ACTIVE;
                        end
                    end else if (resumeReq || resSync_q[1]) begin
                        cnt_q <= 32'h0000_0001;
                    end
                end
                default: stage_q <= stage_q;
            endcase
        end
    end

    // Fallback cycles power at same class, contact interface selected one cycle before the power drop
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            powerCycle_q <= 1'b0;
        end else begin
            // One pulse on entry only, else the card would be cycled forever
            powerCycle_q <= stage_q == ucas_pkg::ST_FALLBACK && !contactSelect;
        end
    end

    // Remembers that the card started the resume
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            remoteWake_q <= 1'b0;
        end else if (stage_q != ucas_pkg::ST_SUSPEND) begin
            remoteWake_q <= 1'b0;
        end else if (resSync_q[1]) begin
            remoteWake_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            link.busReset    <= 1'b0;
            link.busActivity <= 1'b0;
            link.addrAssign  <= 1'b0;
            link.powerNeg    <= 1'b0;
            link.configOk    <= 1'b0;
            link.configFail  <= 1'b0;
            link.powerOnReq  <= 1'b0;
            link.hostResume  <= 1'b0;
            link.wakeEnable  <= 1'b0;
            link.cardPower   <= 1'b0;
            contactSelect    <= 1'b0;
            wakeActions      <= 1'b0;
            active           <= 1'b0;
        end else begin
            link.busReset    <= stage_q == ucas_pkg::ST_RESET;
            link.busActivity <= stage_q == ucas_pkg::ST_ACTIVE && trafficReq;
            link.addrAssign  <= stage_q == ucas_pkg::ST_ADDRESS;
            link.powerNeg    <= stage_q == ucas_pkg::ST_POWER;
            link.configOk    <= stage_q == ucas_pkg::ST_CONFIG && cfgDone && cfgResult;
            link.configFail  <= stage_q == ucas_pkg::ST_CONFIG && cfgDone && !cfgResult;
            // Answer fields like clock stop are ignored upstream
            // One cycle after configuration, so the card is already active
            link.powerOnReq  <= link.configOk;
            link.hostResume  <= stage_q == ucas_pkg::ST_SUSPEND && cnt_q != 32'h0000_0000;
            link.wakeEnable  <= stage_q == ucas_pkg::ST_ACTIVE || stage_q == ucas_pkg::ST_SUSPEND;
            link.cardPower   <= powerReq && !powerCycle_q;
            contactSelect    <= stage_q == ucas_pkg::ST_FALLBACK;
            wakeActions      <= stage_q == ucas_pkg::ST_SUSPEND && cnt_q == 32'(RESUME_CYC - 1)
                                && remoteWake_q;
            active           <= stage_q == ucas_pkg::ST_ACTIVE;
        end
    end
endmodule

/* File: logic/ucas_link_if.sv */
// Link signals between card and terminal ends
`timescale 1ns/1ns
interface ucas_link_if;
    logic       attach;
    logic       busReset;
    logic       busActivity;
    logic       addrAssign;
    logic       powerNeg;
    logic       configOk;
    logic       configFail;
    logic       powerOnReq;
    logic       answerValid;
    logic [7:0] answerByte;
    logic       answerLast;
    logic       cardResume;
    logic       hostResume;
    logic       wakeEnable;
    logic       fullSpeed;
    logic       cardPower;
    modport card (
        input  busReset, busActivity, addrAssign, powerNeg, configOk, configFail,
               powerOnReq, hostResume, wakeEnable, cardPower,
        output attach, answerValid, answerByte, answerLast, cardResume, fullSpeed
    );
    modport host (
        output busReset, busActivity, addrAssign, powerNeg, configOk, configFail,
               powerOnReq, hostResume, wakeEnable, cardPower,
        input  attach, answerValid, answerByte, answerLast, cardResume, fullSpeed
    );
endinterface

/* File: logic/ucas_pkg.sv */
// Types shared by both ends of the card link
package ucas_pkg;
    typedef enum logic [2:0] {
        ST_DETACHED,
        ST_RESET,
        ST_ADDRESS,
        ST_POWER,
        ST_CONFIG,
        ST_ACTIVE,
        ST_SUSPEND,
        ST_FALLBACK
    } ucas_stage_t;
endpackage

/* File: sim/test_usb_card_activation_suspend.sv */
// Bench: both ends joined, activation, answer, suspend, wakeup, fallback
`timescale 1ns/1ns
module test_usb_card_activation_suspend;
    localparam int          IDLE = 50;
    localparam int          WAKE = 30;
    localparam logic [63:0] ANS  = 64'h5A3C_0F96_E1D2_4B78; // Arbitrary
    logic clk, reset_n, powerReq, cfgResult, cfgDone, suspendReq, resumeReq;
    logic trafficReq, wakeRequest, extWake, suspended, configured, pullEnable;
    logic dataPlusContact, dataMinusContact, contactSelect, wakeActions, active;
    int   miscompares, cmp_count, n, gap;
    logic [7:0] rx[$];
    ucas_link_if link ();
    ucas_card #(.IDLE_CYC(IDLE), .WAKE_CYC(WAKE), .RESET_ANSWER(ANS)) ucas_card_i (
        .clk(clk), .reset_n(reset_n), .link(link), .wakeRequest(wakeRequest),
        .extWake(extWake), .suspended(suspended), .configured(configured),
        .pullEnable(pullEnable), .dataPlusContact(dataPlusContact),
        .dataMinusContact(dataMinusContact));
    ucas_host #(.RESET_CYC(5), .RESUME_CYC(60)) ucas_host_i (
        .clk(clk), .reset_n(reset_n), .link(link), .powerReq(powerReq),
        .cfgResult(cfgResult), .cfgDone(cfgDone), .suspendReq(suspendReq),
        .resumeReq(resumeReq), .trafficReq(trafficReq),
        .contactSelect(contactSelect), .wakeActions(wakeActions), .active(active));
    ucas_link_chk #(.WAKE_CYC(WAKE), .ANSWER(ANS)) ucas_link_chk_i (
        .clk(clk), .reset_n(reset_n), .attach(link.attach), .busReset(link.busReset),
        .addrAssign(link.addrAssign), .powerNeg(link.powerNeg),
        .configOk(link.configOk), .configFail(link.configFail),
        .powerOnReq(link.powerOnReq), .answerValid(link.answerValid),
        .answerByte(link.answerByte), .answerLast(link.answerLast),
        .cardResume(link.cardResume), .hostResume(link.hostResume),
        .wakeEnable(link.wakeEnable), .fullSpeed(link.fullSpeed));
    function automatic logic [63:0] ans_byte(input int i);
        return {56'h0, ANS[8*(7-i) +: 8]};
    endfunction
    function automatic logic [63:0] idle_ok(input int c);
        return {63'h0, c >= IDLE - 2 && c <= IDLE + 4};
    endfunction
    task automatic check(input string nm, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Full restart, then configuration reported as ok or failed
    task automatic bring_up(input logic ok);
        reset_n <= 1'b0;
        powerReq <= 1'b0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        cfgResult <= ok;
        @(posedge clk) powerReq <= 1'b1;
        for (n = 0; n < 400 && link.powerNeg !== 1'b1; n++) @(negedge clk);
        @(posedge clk) cfgDone <= 1'b1;
        @(posedge clk) cfgDone <= 1'b0;
        for (n = 0; n < 100 && active !== 1'b1 && contactSelect !== 1'b1; n++) @(negedge clk);
    endtask
    task automatic idle_wait();
        @(posedge clk) trafficReq <= 1'b1;
        @(posedge clk) begin
            trafficReq <= 1'b0;
            suspendReq <= 1'b1;
        end
        @(posedge clk) suspendReq <= 1'b0;
        for (n = 0; n < IDLE * 3 && suspended !== 1'b1; n++) @(negedge clk);
        check("suspend delay", 64'h1, idle_ok(n));
        check("resistor off", 64'h0, pullEnable);
        check("idle line", 64'h2, {dataPlusContact, dataMinusContact});
    endtask
    always @(negedge clk) if (link.answerValid === 1'b1) rx.push_back(link.answerByte);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        final_report();
    end
    initial begin
        {reset_n, powerReq, cfgResult, cfgDone, suspendReq, resumeReq} = 6'h00;
        {trafficReq, wakeRequest, extWake} = 3'h0;
        void'($urandom(32'h4da2_0338));
        extWake <= 1'($urandom);
        bring_up(1'b1);
        check("active", 64'h1, active);
        for (n = 0; n < 100 && rx.size() < 8; n++) @(negedge clk);
        check("configured", 64'h1, configured);
        check("answer count", 64'h8, rx.size());
        foreach (rx[i]) check("answer byte", ans_byte(i), rx[i]);
        // Gaps just under the idle limit are the corner case
        for (int k = 0; k < 8; k++) begin
            gap = (k == 7) ? IDLE - 3 : $urandom_range(IDLE - 10, 1);
            @(posedge clk) trafficReq <= 1'b1;
            @(posedge clk) trafficReq <= 1'b0;
            repeat (gap) @(negedge clk);
            check("early suspend", 64'h0, suspended);
        end
        idle_wait();
        @(posedge clk) wakeRequest <= 1'b1;
        repeat (4) @(posedge clk);
        wakeRequest <= 1'b0;
        for (n = 0; n < 100 && link.cardResume !== 1'b1; n++) @(negedge clk);
        check("card resume", 64'h1, link.cardResume);
        check("resume line", 64'h1, {dataPlusContact, dataMinusContact});
        check("resistor on", 64'h1, pullEnable);
        for (n = 0; n < 200 && wakeActions !== 1'b1; n++) @(negedge clk);
        check("wake actions", 64'h1, wakeActions);
        for (n = 0; n < 200 && suspended !== 1'b0; n++) @(negedge clk);
        check("resumed", 64'h0, suspended);
        idle_wait();
        @(posedge clk) resumeReq <= 1'b1;
        @(posedge clk) resumeReq <= 1'b0;
        for (n = 0; n < 300 && suspended !== 1'b0; n++) @(negedge clk);
        check("host resumed", 64'h0, suspended);
        @(posedge clk);
        bring_up(1'b0);
        check("contact fallback", 64'h1, contactSelect);
        check("not active", 64'h0, active);
        final_report();
    end
endmodule

/* File: sim/ucas_link_chk.sv */
// Assertions on the link between card and terminal ends
`timescale 1ns/1ns
module ucas_link_chk #(
    parameter int          WAKE_CYC = 30,
    parameter logic [63:0] ANSWER   = 64'h0000_0000_0000_0000
) (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       attach,
    input wire logic       busReset,
    input wire logic       addrAssign,
    input wire logic       powerNeg,
    input wire logic       configOk,
    input wire logic       configFail,
    input wire logic       powerOnReq,
    input wire logic       answerValid,
    input wire logic [7:0] answerByte,
    input wire logic       answerLast,
    input wire logic       cardResume,
    input wire logic       hostResume,
    input wire logic       wakeEnable,
    input wire logic       fullSpeed
);
    logic [2:0] seen_q;
    logic [3:0] idx_q;
    logic [7:0] wLen_q;
    logic [7:0] hLen_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Stage history, restarted by every bus reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) seen_q <= 3'h0;
        else if (busReset) seen_q <= 3'h1;
        else seen_q <= seen_q | {powerNeg & seen_q[1], addrAssign & seen_q[0], 1'b0};
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) idx_q <= 4'h0;
        else idx_q <= answerValid ? idx_q + 4'h1 : 4'h0;
    end
    // Length counters; 8 bits suffice for the shortened counts only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) wLen_q <= 8'h00;
        else wLen_q <= cardResume ? wLen_q + 8'h01 : 8'h00;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) hLen_q <= 8'h00;
        else hLen_q <= hostResume ? hLen_q + 8'h01 : 8'h00;
    end
    a_addr_after_reset: assert property ($rose(addrAssign) |-> seen_q[0])
        else $error("address stage without bus reset");
    a_power_after_addr: assert property ($rose(powerNeg) |-> seen_q[1])
        else $error("power stage before address");
    a_config_after_power: assert property (configOk |-> seen_q[2])
        else $error("configuration before power stage");
    a_answer_latency: assert property ($rose(answerValid) |-> $past(powerOnReq, 2))
        else $error("answer not two cycles after request");
    a_answer_bytes: assert property (answerValid |->
        answerByte == ANSWER[8*(7-int'(idx_q)) +: 8])
        else $error("answer byte differs");
    a_answer_last: assert property (answerLast |-> answerValid && idx_q == 4'h7)
        else $error("last flag on wrong byte");
    a_wake_enabled: assert property ($rose(cardResume) |-> wakeEnable)
        else $error("wakeup while not enabled");
    a_wake_length: assert property ($fell(cardResume) |->
        wLen_q >= WAKE_CYC*4/5 && wLen_q <= WAKE_CYC*6/5)
        else $error("wakeup signalling length out of range");
    a_host_outlasts: assert property ($fell(hostResume) |-> hLen_q > WAKE_CYC)
        else $error("host resume too short");
    a_speed_full: assert property (attach |-> fullSpeed)
        else $error("attached without full speed");
    a_reset_on_attach: assert property ($rose(attach) |-> ##[1:20] busReset)
        else $error("no bus reset after attach");
    c_answer: cover property (answerLast);
    c_wake: cover property ($fell(cardResume));
    c_host_resume: cover property ($fell(hostResume));
    c_fail: cover property (configFail);
endmodule
